// ==== hw/iscs_core.sv ====
`timescale 1ns/10ps
`include "iscs_params.svh"
// Notes on behaviour
// - target reply: anode volts, amps, then run, start, cap per gas channel
// - last target field is neutralizer ratio percent or current, per setpoint in use
// - version reply carries vv.vv version; framing done by serializer
// - clear-event removes oldest event only when tag matches
// - disable takes type code 000/001/002/004 and stops that type
// - arm takes the same codes and resumes that type
// - mute-all stops every event type
// - lock argument '0' unlocks, '1' locks
// - mode argument '0' manual, '1' automatic
// - anode, filament and gas switches act only in manual mode
// - beam switch acts only in automatic mode
// - anode current setpoint only in auto with its feature on
// - filament current in auto with feature on, or in manual
// - filament cap sets largest AC filament current
// - each gas channel keeps its own flow cap
// - master select names one channel, replacing previous
// - run share percent of master flow, per channel, in auto
// - each channel keeps a start flow for auto startup
// - flow set: channel 1 manual or auto+gas feature; 2,3 manual only
// - emission setpoint only in auto with its feature on
// - neutralizer as current or ratio in auto with feature on
// - anode voltage always stored
// - each new event tag is previous plus one
// - event reply flag '1' if more events wait, else '0'
module iscs_core (
    input wire logic i_clock, // 125 MHz
    input wire logic i_sys_rst, // sync reset
    input wire logic i_cmd_valid, // decoded command strobe
    input wire iscs_pkg::iscs_cmd_s i_cmd, // decoded command
    input wire iscs_pkg::iscs_cfg_s i_feat, // auto-mode feature selects
    input wire logic i_evt_valid, // new event strobe
    input wire logic [2:0] i_evt_type, // event type code
    input wire logic [7:0] i_evt_code, // event code
    input wire logic [15:0] i_evt_data, // event data
    output logic o_auto_mode, // 1 = automatic
    output logic o_locked, // 1 = locked
    output logic o_anode_on, // anode switch
    output logic o_fil_on, // filament switch
    output logic o_beam_on, // beam switch
    output logic [2:0] o_gas_on, // gas channel switches
    output logic [1:0] o_master, // master channel 1..3, 0 none
    output logic [19:0] o_fil_i, // filament current
    output logic [19:0] o_fil_cap, // filament current cap
    output logic [19:0] o_emis_i, // emission current
    output logic [59:0] o_run_share, // per-channel run share percent
    output logic [`ISCS_EVT_TYPES-1:0] o_evt_mask, // enabled event types
    output iscs_pkg::iscs_target_s o_target, // target-state reply
    output logic [15:0] o_version, // version digits
    output logic o_reply_valid, // reply strobe
    output iscs_pkg::iscs_cmd_e o_reply_kind, // which query
    output logic o_evt_present, // queue not empty
    output iscs_pkg::iscs_evt_s o_evt_head, // oldest event
    output logic [7:0] o_evt_more // '0' or '1'
);
    // ==========================================================
    // command qualification
    wire logic go = i_cmd_valid && i_cmd.sum_ok && (i_cmd.cmd != iscs_pkg::ISCS_CMD_NONE);
    wire logic manual = !o_auto_mode;
    wire logic arg0 = i_cmd.arg_char == `ISCS_CHAR_ZERO;
    wire logic arg1 = i_cmd.arg_char == `ISCS_CHAR_ONE;
    wire logic chan_ok = (i_cmd.chan != 2'h0);
    wire logic [1:0] ci = i_cmd.chan - 2'h1;
    wire logic is_cmd [25];
    wire logic [2:0] tcode = i_cmd.tag[2:0];
    // type codes 000,001,002,004 map to mask bits 0,1,2,4
    wire logic type_ok = (i_cmd.tag[11:3] == 9'h0) && (tcode != 3'h3) && (tcode <= 3'h4);
    genvar g;
    generate
        for (g = 0; g < 25; g++) begin : g_dec
            assign is_cmd[g] = go && (i_cmd.cmd == iscs_pkg::iscs_cmd_e'(g));
        end
    endgenerate
    wire logic sw_val = i_cmd.value[0];
    wire logic do_anode_sw = is_cmd[iscs_pkg::ISCS_CMD_ANODE_SW] && manual;
    wire logic do_fil_sw = is_cmd[iscs_pkg::ISCS_CMD_FIL_SW] && manual;
    wire logic do_gas_sw = is_cmd[iscs_pkg::ISCS_CMD_GAS_SW] && manual && chan_ok;
    wire logic do_beam = is_cmd[iscs_pkg::ISCS_CMD_BEAM_SW] && o_auto_mode;
    wire logic do_ai = is_cmd[iscs_pkg::ISCS_CMD_ANODE_I] && o_auto_mode && i_feat.ai_feat;
    wire logic do_ci = is_cmd[iscs_pkg::ISCS_CMD_FIL_I] && (manual || i_feat.ci_feat);
    wire logic do_ei = is_cmd[iscs_pkg::ISCS_CMD_EMIS_I] && o_auto_mode && i_feat.ei_feat;
    wire logic neut_ok = o_auto_mode && i_feat.ni_feat;
    wire logic do_ni = is_cmd[iscs_pkg::ISCS_CMD_NEUT_I] && neut_ok;
    wire logic do_nr = is_cmd[iscs_pkg::ISCS_CMD_NEUT_R] && neut_ok;
    wire logic flow_mode_ok = manual || (i_cmd.chan == 2'h1 && i_feat.sg_feat);
    wire logic do_flow = is_cmd[iscs_pkg::ISCS_CMD_GAS_FLOW] && chan_ok && flow_mode_ok;
    wire logic do_cap = is_cmd[iscs_pkg::ISCS_CMD_GAS_CAP] && chan_ok;
    wire logic do_master = is_cmd[iscs_pkg::ISCS_CMD_GAS_MASTER] && chan_ok;
    // share and start flow are held at any time, used by auto-mode logic downstream
    wire logic do_share = is_cmd[iscs_pkg::ISCS_CMD_GAS_SHARE] && chan_ok;
    wire logic do_start = is_cmd[iscs_pkg::ISCS_CMD_GAS_START] && chan_ok;

    // ==========================================================
    // modes and switches
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_auto_mode <= 1'b0;
            o_locked <= 1'b0;
            o_anode_on <= 1'b0;
            o_fil_on <= 1'b0;
            o_beam_on <= 1'b0;
            o_master <= 2'h0;
        end else begin
            if (is_cmd[iscs_pkg::ISCS_CMD_MODE] && (arg0 || arg1)) begin
                o_auto_mode <= arg1;
            end
            if (is_cmd[iscs_pkg::ISCS_CMD_LOCK] && (arg0 || arg1)) begin
                o_locked <= arg1;
            end
            if (do_anode_sw) begin
                o_anode_on <= sw_val;
            end
            if (do_fil_sw) begin
                o_fil_on <= sw_val;
            end
            if (do_beam) begin
                o_beam_on <= sw_val;
            end
            if (do_master) begin
                o_master <= i_cmd.chan;
            end
        end
    end

    // ==========================================================
    // setpoints
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_target <= '0;
            o_fil_i <= 20'h0;
            o_fil_cap <= 20'h0;
            o_emis_i <= 20'h0;
        end else begin
            if (is_cmd[iscs_pkg::ISCS_CMD_ANODE_V]) begin
                o_target.anode_v <= i_cmd.value;
            end
            if (do_ai) begin
                o_target.anode_i <= i_cmd.value;
            end
            if (do_ci) begin
                o_fil_i <= i_cmd.value;
            end
            if (is_cmd[iscs_pkg::ISCS_CMD_FIL_CAP]) begin
                o_fil_cap <= i_cmd.value;
            end
            if (do_ei) begin
                o_emis_i <= i_cmd.value;
            end
            if (do_ni || do_nr) begin
                o_target.neut_val <= i_cmd.value;
                o_target.neut_is_ratio <= do_nr;
            end
            if (do_flow) begin
                o_target.run_flow[ci] <= i_cmd.value;
            end
            if (do_cap) begin
                o_target.flow_cap[ci] <= i_cmd.value;
            end
            if (do_start) begin
                o_target.start_flow[ci] <= i_cmd.value;
            end
        end
    end

    generate
        for (g = 0; g < 3; g++) begin : g_gas
            always_ff @(posedge i_clock) begin
                if (i_sys_rst) begin
                    o_gas_on[g] <= 1'b0;
                    o_run_share[g*20 +: 20] <= 20'h0;
                end else begin
                    if (do_gas_sw && ci == 2'(g)) begin
                        o_gas_on[g] <= sw_val;
                    end
                    if (do_share && ci == 2'(g)) begin
                        o_run_share[g*20 +: 20] <= i_cmd.value;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // replies; target struct order is the reply field order
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_reply_valid <= 1'b0;
            o_reply_kind <= iscs_pkg::ISCS_CMD_NONE;
            o_version <= 16'h0;
        end else begin
            o_version <= {`ISCS_VERSION_MAJ, `ISCS_VERSION_MIN};
            o_reply_valid <= is_cmd[iscs_pkg::ISCS_CMD_TARGET_QUERY] ||
                is_cmd[iscs_pkg::ISCS_CMD_VERSION_QUERY];
            o_reply_kind <= go ? i_cmd.cmd : iscs_pkg::ISCS_CMD_NONE;
        end
    end

    // ==========================================================
    // event mask and queue
    wire logic evt_type_ok = (i_evt_type != 3'h3) && (i_evt_type <= 3'h4);
    wire logic evt_enabled = evt_type_ok && o_evt_mask[i_evt_type];
    logic [`ISCS_EVQ_AW-1:0] wr_ptr_r, rd_ptr_r;
    logic [`ISCS_EVQ_AW:0] count_r;
    logic [`ISCS_TAG_W-1:0] tag_r;
    wire logic full = count_r == (`ISCS_EVQ_AW+1)'(`ISCS_EVQ_DEPTH);
    // a full queue drops new events; the host must clear to make room
    wire logic push = i_evt_valid && evt_enabled && !full;
    wire logic pop = is_cmd[iscs_pkg::ISCS_CMD_CLEAR_EVENT] && (count_r != '0) &&
        (i_cmd.tag == o_evt_head.tag);
    wire logic [`ISCS_EVQ_AW-1:0] rd_next = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    // one next-count feeds the counter and the flags so they cannot drift apart
    wire logic [`ISCS_EVQ_AW:0] count_nxt = count_r + (`ISCS_EVQ_AW+1)'(push) - (`ISCS_EVQ_AW+1)'(pop);
    wire logic more_nxt = count_nxt > (`ISCS_EVQ_AW+1)'(1);
    iscs_pkg::iscs_evt_s new_evt;
    assign new_evt = '{tag: tag_r, code: i_evt_code, data: i_evt_data};

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_evt_mask <= `ISCS_EVT_MASK_RST;
        end else if (is_cmd[iscs_pkg::ISCS_CMD_MUTE_ALL]) begin
            o_evt_mask <= '0;
        end else if (is_cmd[iscs_pkg::ISCS_CMD_EVT_DISABLE] && type_ok) begin
            o_evt_mask[tcode] <= 1'b0;
        end else if (is_cmd[iscs_pkg::ISCS_CMD_EVT_ARM] && type_ok) begin
            o_evt_mask[tcode] <= 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            tag_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
                tag_r <= tag_r + 1'b1;
            end
            rd_ptr_r <= rd_next;
            count_r <= count_nxt;
        end
    end

    iscs_evq_mem u_mem (
        .i_clock(i_clock),
        .i_we(push),
        .i_waddr(wr_ptr_r),
        .i_wdata(new_evt),
        .i_raddr(rd_next),
        .o_rdata(o_evt_head)
    );

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_evt_present <= 1'b0;
            o_evt_more <= `ISCS_CHAR_ZERO;
        end else begin
            o_evt_present <= count_nxt != '0;
            o_evt_more <= more_nxt ? `ISCS_CHAR_ONE : `ISCS_CHAR_ZERO;
        end
    end

    // ==========================================================
    // checks
    mode_select_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        is_cmd[iscs_pkg::ISCS_CMD_MODE] && arg1 |=> o_auto_mode) else $error("mode set failed");
    lock_select_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        is_cmd[iscs_pkg::ISCS_CMD_LOCK] && arg0 |=> !o_locked) else $error("unlock failed");
    beam_auto_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        $changed(o_beam_on) |-> $past(o_auto_mode)) else $error("beam moved in manual");
    anode_manual_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        $changed(o_anode_on) |-> !$past(o_auto_mode)) else $error("anode moved in auto");
    mute_all_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        is_cmd[iscs_pkg::ISCS_CMD_MUTE_ALL] |=> o_evt_mask == '0) else $error("mute failed");
    clear_tag_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        is_cmd[iscs_pkg::ISCS_CMD_CLEAR_EVENT] && i_cmd.tag != o_evt_head.tag && !push
        |=> $stable(count_r)) else $error("bad tag cleared event");
    tag_step_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        push |=> tag_r == $past(tag_r) + 1'b1) else $error("tag not incremented");
    anode_volt_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        is_cmd[iscs_pkg::ISCS_CMD_ANODE_V] |=> o_target.anode_v == $past(i_cmd.value))
        else $error("anode volt not stored");
    bad_sum_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_cmd_valid && !i_cmd.sum_ok |=> $stable(o_auto_mode) && $stable(o_target))
        else $error("bad checksum acted");
    ai_gate_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        $changed(o_target.anode_i) |-> $past(o_auto_mode) && $past(i_feat.ai_feat))
        else $error("anode current set outside auto");
    emis_gate_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        $changed(o_emis_i) |-> $past(o_auto_mode) && $past(i_feat.ei_feat))
        else $error("emission set outside auto");
    flow_manual_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        $changed(o_target.run_flow[1]) |-> !$past(o_auto_mode)) else $error("channel 2 flow set in auto");
endmodule

// ==== hw/iscs_params.svh ====
`ifndef ISCS_PARAMS_SVH
`define ISCS_PARAMS_SVH
`define ISCS_EVQ_DEPTH 8
`define ISCS_EVQ_AW 3
`define ISCS_VAL_W 20
`define ISCS_TAG_W 12
`define ISCS_EVT_TYPES 5
`define ISCS_EVT_MASK_RST 5'h17
`define ISCS_CHAR_ZERO 8'h30
`define ISCS_CHAR_ONE 8'h31
`define ISCS_VERSION_MAJ 8'h01
`define ISCS_VERSION_MIN 8'h00
`endif

// ==== hw/iscs_pkg.sv ====
package iscs_pkg;
    typedef enum logic [4:0] {
        ISCS_CMD_NONE, ISCS_CMD_TARGET_QUERY, ISCS_CMD_VERSION_QUERY, ISCS_CMD_CLEAR_EVENT,
        ISCS_CMD_EVT_DISABLE, ISCS_CMD_EVT_ARM, ISCS_CMD_MUTE_ALL, ISCS_CMD_LOCK, ISCS_CMD_MODE,
        ISCS_CMD_ANODE_SW, ISCS_CMD_FIL_SW, ISCS_CMD_BEAM_SW, ISCS_CMD_GAS_SW,
        ISCS_CMD_ANODE_I, ISCS_CMD_ANODE_V, ISCS_CMD_FIL_I, ISCS_CMD_FIL_CAP, ISCS_CMD_EMIS_I,
        ISCS_CMD_NEUT_I, ISCS_CMD_NEUT_R, ISCS_CMD_GAS_FLOW, ISCS_CMD_GAS_CAP, ISCS_CMD_GAS_MASTER,
        ISCS_CMD_GAS_SHARE, ISCS_CMD_GAS_START
    } iscs_cmd_e;
    typedef struct packed {
        iscs_cmd_e cmd;
        logic [1:0] chan;
        logic [19:0] value;
        logic [11:0] tag;
        logic [7:0] arg_char;
        logic sum_ok;
    } iscs_cmd_s;
    typedef struct packed {
        logic auto_mode;
        logic ai_feat;
        logic ci_feat;
        logic ei_feat;
        logic ni_feat;
        logic sg_feat;
    } iscs_cfg_s;
    typedef struct packed {
        logic [11:0] tag;
        logic [7:0] code;
        logic [15:0] data;
    } iscs_evt_s;
    typedef struct packed {
        logic [19:0] anode_v;
        logic [19:0] anode_i;
        logic [2:0][19:0] run_flow;
        logic [2:0][19:0] start_flow;
        logic [2:0][19:0] flow_cap;
        logic neut_is_ratio;
        logic [19:0] neut_val;
    } iscs_target_s;
endpackage

// ==== hw/iscs_evq_mem.sv ====
`timescale 1ns/10ps
`include "iscs_params.svh"
// small event store; read data is registered
module iscs_evq_mem (
    input wire logic i_clock, // system clock
    input wire logic i_we, // write strobe
    input wire logic [`ISCS_EVQ_AW-1:0] i_waddr, // write slot
    input wire iscs_pkg::iscs_evt_s i_wdata, // event to store
    input wire logic [`ISCS_EVQ_AW-1:0] i_raddr, // read slot
    output iscs_pkg::iscs_evt_s o_rdata // registered read data
);
    iscs_pkg::iscs_evt_s mem_r [`ISCS_EVQ_DEPTH];
    always_ff @(posedge i_clock) begin
        if (i_we) begin
            mem_r[i_waddr] <= i_wdata;
        end
        // forward a write into the slot being read, else the head lags a push by one cycle
        if (i_we && (i_waddr == i_raddr)) begin
            o_rdata <= i_wdata;
        end else begin
            o_rdata <= mem_r[i_raddr];
        end
    end
endmodule

// ==== test/iscs_host.sv ====
`timescale 1ns/10ps
// ========================================
// remote host model: one decoded command per strobe
module iscs_host (
    input wire logic i_clock, // system clock
    output logic o_cmd_valid, // command strobe
    output iscs_pkg::iscs_cmd_s o_cmd // decoded command
);
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd = '0;
    end
    // strobe drops after one taken edge, so back-to-back calls leave a one-cycle gap
    task automatic send(input iscs_pkg::iscs_cmd_e c, input logic [1:0] ch = 2'h0, input logic [19:0] v = 20'h0,
                        input logic [11:0] t = 12'h0, input logic [7:0] a = 8'h0, input logic ok = 1'b1);
        @(negedge i_clock);
        o_cmd = '{cmd: c, chan: ch, value: v, tag: t, arg_char: a, sum_ok: ok};
        o_cmd_valid = 1'b1;
        @(negedge i_clock);
        o_cmd_valid = 1'b0;
        // released fields stop showing the last command
        o_cmd = ~o_cmd;
    endtask
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/10ps
module testbench;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    iscs_pkg::iscs_cfg_s feat = '0;
    logic evt_valid = 1'b0;
    logic [2:0] evt_type = 3'h0;
    logic cmd_valid;
    iscs_pkg::iscs_cmd_s cmd;
    logic auto_mode, locked, anode_on, fil_on, beam_on, reply_valid, evt_present;
    logic [2:0] gas_on;
    logic [1:0] master;
    logic [19:0] fil_i, fil_cap, emis_i;
    logic [59:0] run_share;
    logic [4:0] evt_mask;
    iscs_pkg::iscs_target_s tgt;
    logic [15:0] version;
    iscs_pkg::iscs_cmd_e reply_kind;
    iscs_pkg::iscs_evt_s head;
    logic [7:0] more;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;

    always #4 i_clock = ~i_clock;

    iscs_host iscs_host_i (.i_clock(i_clock), .o_cmd_valid(cmd_valid), .o_cmd(cmd));
    iscs_core iscs_core_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
        .i_feat(feat), .i_evt_valid(evt_valid), .i_evt_type(evt_type), .i_evt_code(8'h03),
        .i_evt_data(16'h1234), .o_auto_mode(auto_mode), .o_locked(locked), .o_anode_on(anode_on),
        .o_fil_on(fil_on), .o_beam_on(beam_on), .o_gas_on(gas_on), .o_master(master), .o_fil_i(fil_i),
        .o_fil_cap(fil_cap), .o_emis_i(emis_i), .o_run_share(run_share), .o_evt_mask(evt_mask),
        .o_target(tgt), .o_version(version), .o_reply_valid(reply_valid), .o_reply_kind(reply_kind),
        .o_evt_present(evt_present), .o_evt_head(head), .o_evt_more(more));

    // ========================================
    // helpers
    task automatic check(input string what, input logic [59:0] exp, input logic [59:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // returns one half cycle after the taking edge, when head and flags must already stand
    task automatic push(input logic [2:0] ty);
        @(negedge i_clock);
        evt_valid = 1'b1;
        evt_type = ty;
        @(negedge i_clock);
        evt_valid = 1'b0;
    endtask

    task automatic results();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ========================================
    // scenarios
    task automatic t_modes();
        iscs_host_i.send(iscs_pkg::ISCS_CMD_LOCK, 0, 0, 0, 8'h31);
        check("locked", 1, locked);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_LOCK, 0, 0, 0, 8'h32);
        check("locked bad arg", 1, locked);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_LOCK, 0, 0, 0, 8'h30);
        check("unlocked", 0, locked);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_MODE, 0, 0, 0, 8'h31);
        check("auto", 1, auto_mode);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_MODE, 0, 0, 0, 8'h30);
        check("manual", 0, auto_mode);
    endtask

    task automatic t_switches();
        iscs_host_i.send(iscs_pkg::ISCS_CMD_ANODE_SW, 0, 1);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_FIL_SW, 0, 1);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_GAS_SW, 2, 1);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_BEAM_SW, 0, 1);
        check("manual switches", 5'h1a, {anode_on, fil_on, gas_on});
        check("beam in manual", 0, beam_on);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_MODE, 0, 0, 0, 8'h31);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_ANODE_SW, 0, 0);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_BEAM_SW, 0, 1);
        check("anode in auto", 1, anode_on);
        check("beam in auto", 1, beam_on);
    endtask

    // entered in auto mode with no features selected
    task automatic t_setpoints();
        iscs_host_i.send(iscs_pkg::ISCS_CMD_ANODE_I, 0, 20'h5);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_FIL_I, 0, 20'h8);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_EMIS_I, 0, 20'h9);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_GAS_FLOW, 1, 20'h10);
        check("gated setpoints", 0, {tgt.anode_i, fil_i, emis_i, tgt.run_flow[0]});
        iscs_host_i.send(iscs_pkg::ISCS_CMD_ANODE_V, 0, 20'h11);
        check("anode volts", 20'h11, tgt.anode_v);
        feat = '{auto_mode: 1'b0, ai_feat: 1'b1, ci_feat: 1'b1, ei_feat: 1'b1, ni_feat: 1'b1, sg_feat: 1'b1};
        iscs_host_i.send(iscs_pkg::ISCS_CMD_ANODE_I, 0, 20'h5);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_FIL_I, 0, 20'h8);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_EMIS_I, 0, 20'h9);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_FIL_CAP, 0, 20'h123);
        check("auto setpoints", 60'h5_00008_00009, {tgt.anode_i, fil_i, emis_i});
        check("filament cap", 20'h123, fil_cap);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_NEUT_I, 0, 20'h40);
        check("neutralizer current", 21'h40, {tgt.neut_is_ratio, tgt.neut_val});
        iscs_host_i.send(iscs_pkg::ISCS_CMD_NEUT_R, 0, 20'h32);
        check("neutralizer ratio", 21'h100032, {tgt.neut_is_ratio, tgt.neut_val});
        iscs_host_i.send(iscs_pkg::ISCS_CMD_GAS_FLOW, 1, 20'h10);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_GAS_FLOW, 2, 20'h20);
        check("auto flows", 40'h00010_00000, {tgt.run_flow[0], tgt.run_flow[1]});
        iscs_host_i.send(iscs_pkg::ISCS_CMD_MODE, 0, 0, 0, 8'h30);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_GAS_FLOW, 2, 20'h20);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_FIL_I, 0, 20'h7);
        check("manual flow ch2", 20'h20, tgt.run_flow[1]);
        check("manual filament", 20'h7, fil_i);
    endtask

    task automatic t_gas();
        for (int ch = 1; ch <= 3; ch++) begin
            iscs_host_i.send(iscs_pkg::ISCS_CMD_GAS_CAP, 2'(ch), 20'(ch * 256));
            iscs_host_i.send(iscs_pkg::ISCS_CMD_GAS_START, 2'(ch), 20'(ch * 16));
            iscs_host_i.send(iscs_pkg::ISCS_CMD_GAS_SHARE, 2'(ch), 20'(ch * 5));
            iscs_host_i.send(iscs_pkg::ISCS_CMD_GAS_MASTER, 2'(ch));
            check("master", ch, master);
        end
        for (int ch = 0; ch < 3; ch++) begin
            check("flow cap", (ch + 1) * 256, tgt.flow_cap[ch]);
            check("start flow", (ch + 1) * 16, tgt.start_flow[ch]);
            check("run share", (ch + 1) * 5, run_share[20 * ch +: 20]);
        end
    endtask

    task automatic t_queries();
        iscs_host_i.send(iscs_pkg::ISCS_CMD_TARGET_QUERY);
        check("target reply", {1'b1, iscs_pkg::ISCS_CMD_TARGET_QUERY}, {reply_valid, reply_kind});
        @(negedge i_clock);
        check("reply one cycle", 0, reply_valid);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_VERSION_QUERY);
        check("version reply", {1'b1, iscs_pkg::ISCS_CMD_VERSION_QUERY, 16'h0100}, {reply_valid, reply_kind, version});
    endtask

    task automatic t_events();
        check("mask reset", 5'h17, evt_mask);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_EVT_DISABLE, 0, 0, 12'h1);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_EVT_DISABLE, 0, 0, 12'h4);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_EVT_DISABLE, 0, 0, 12'h3);
        check("disable", 5'h05, evt_mask);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_EVT_ARM, 0, 0, 12'h1);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_EVT_ARM, 0, 0, 12'h4);
        check("arm", 5'h17, evt_mask);
        push(3'h0);
        check("first event", {1'b1, 12'h0, 8'h03, 16'h1234, 8'h30}, {evt_present, head, more});
        push(3'h2);
        check("more waiting", 8'h31, more);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_CLEAR_EVENT, 0, 0, 12'h5);
        @(negedge i_clock);
        check("wrong tag kept", 0, head.tag);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_CLEAR_EVENT, 0, 0, 12'h0);
        @(negedge i_clock);
        check("next event", {1'b1, 12'h1, 8'h30}, {evt_present, head.tag, more});
        iscs_host_i.send(iscs_pkg::ISCS_CMD_CLEAR_EVENT, 0, 0, 12'h1);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_MUTE_ALL);
        check("mute all", 0, evt_mask);
        push(3'h0);
        check("muted event dropped", 0, evt_present);
    endtask

    task automatic t_refused();
        iscs_host_i.send(iscs_pkg::ISCS_CMD_ANODE_V, 0, 20'h77, 0, 0, 1'b0);
        iscs_host_i.send(iscs_pkg::ISCS_CMD_NONE, 0, 20'h77);
        check("bad sum ignored", 20'h11, tgt.anode_v);
    endtask

    // ========================================
    // sequence and hang guard
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            $display("[FAIL] timeout expected done seen hang");
            results();
        end
    end

    initial begin
        repeat (8) @(negedge i_clock);
        i_sys_rst = 1'b0;
        t_events();
        t_modes();
        t_switches();
        t_setpoints();
        t_gas();
        t_queries();
        t_refused();
        results();
    end
endmodule
